// ---- design/adc_channel_sequencer.sv ----
// Purpose: chooses the analog input for each conversion frame
// Assumes: host keeps chip select low for at least sixteen serial clock falling edges
// Notes: frame words cross to the core clock by toggle handshake with held data
//
// What this block does
// R1: Sequencer off: each write picks next channel
// R2: Mode 0,1: next write loads channel mask
// R3: Advance to next selected channel per frame
// R4: Any mask bit pattern, non-adjacent allowed
// R5: Mode 1,0 write keeps sequence running
// R6: Mode 1,1: sweep channel 0 to address
// R7: Mask is 16 bits, write-only
// R8: Mask shifts in over sixteen falling edges
// R9: Mask captured only after 0,1 write
// R10: First bit is channel 0, sequence one
// R11: Sequence one runs before sequence two
// R12: Ascending order until non 1,0 write
// R13: Host exits with write, both bits 0
// R14: Serial clock drives transfer and conversion
// R15: Control bit 1 selects input range
// R16: Address loaded at end of conversion
// R17: Mux switches on fourteenth falling edge
// R18: Sequencer bits at control 10 and 3
// R19: Reset into single mode, zero mask
`timescale 1ns/1ns
module adc_channel_sequencer
  import adc_seq_pkg::*;
#(
  parameter int NUM_CHANNELS = CHANNELS
) (
  // Core clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Serial link from the host
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  // Converter steering
  output logic [2:0] mux_chan_o,
  output logic [2:0] conv_chan_o,
  output logic range_single_ref_o,
  output logic coding_binary_o,
  output logic [1:0] power_mode_o,
  output seq_mode_t seq_mode_o,
  output logic frame_done_o
);

  // Channel search and mask mapping serve eight inputs only
  if (NUM_CHANNELS != CHANNELS) begin : g_bad_channels
    $error("NUM_CHANNELS must be 8");
  end

  // ****************************************
  // Functions
  // ****************************************
  function automatic ctrl_fields_t decode_ctrl(input logic [15:0] w);
    ctrl_fields_t f;
    f.seq_enable = w[SEQ_ENABLE_POS]; // [R18]
    f.mask_prog = w[MASK_PROG_POS]; // [R18]
    f.chan_addr = w[CHAN_ADDR_HI:CHAN_ADDR_LO];
    f.power_mode = w[POWER_MODE_HI:POWER_MODE_LO];
    f.range_single_ref = w[RANGE_POS]; // [R15]
    f.coding_binary = w[CODING_POS];
    return f;
  endfunction

  // Lowest set bit of an 8-bit group at or above a start channel
  function automatic logic [3:0] first_at_or_above(input logic [7:0] g, input logic [3:0] from);
    logic [3:0] hit;
    hit = 4'h8;
    for (int i = 7; i >= 0; i--) begin
      if (g[i] && 4'(i) >= from) begin
        hit = 4'(i);
      end
    end
    return hit;
  endfunction

  // Bit k of a sequence byte is channel k: the first shifted bit sits at the byte top
  function automatic logic [7:0] to_chan_order(input logic [7:0] b);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) begin
      r[i] = b[7 - i]; // [R10]
    end
    return r;
  endfunction

  // ****************************************
  // Link domain
  // ****************************************
  logic [15:0] link_word;
  logic link_toggle;
  logic [2:0] next_chan_reg;

  // Serial clock doubles as the conversion clock, so the mux lives there [R14]
  frame_shifter u_shift (
    .sclk_i(sclk_i),
    .cs_n_i(cs_n_i),
    .din_i(din_i),
    .next_chan_i(next_chan_reg),
    .shift_o(link_word),
    .frame_toggle_o(link_toggle),
    .mux_chan_o(mux_chan_o)
  );

  // ****************************************
  // Crossing to the core clock
  // ****************************************
  logic tog_meta_reg;
  logic tog_sync_reg;
  logic tog_seen_reg;
  logic tog_last_reg;
  logic [15:0] word_meta_reg;
  logic [15:0] word_sync_reg;
  logic frame_evt;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tog_meta_reg <= 1'b0;
      tog_sync_reg <= 1'b0;
    end else begin
      tog_meta_reg <= link_toggle;
      tog_sync_reg <= tog_meta_reg;
    end
  end

  // Event lags the synchroniser a cycle so the word stages have settled first
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tog_seen_reg <= 1'b0;
      tog_last_reg <= 1'b0;
    end else begin
      tog_seen_reg <= tog_sync_reg;
      tog_last_reg <= tog_seen_reg;
    end
  end

  // Word is held steady until the next frame's end, long past the toggle's arrival
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      word_meta_reg <= 16'h0000;
      word_sync_reg <= 16'h0000;
    end else begin
      word_meta_reg <= link_word;
      word_sync_reg <= word_meta_reg;
    end
  end

  assign frame_evt = tog_seen_reg ^ tog_last_reg;

  // ****************************************
  // Sequencer state
  // ****************************************
  seq_mode_t mode_reg;
  logic [15:0] mask_reg;
  logic [2:0] sweep_last_reg;
  logic [2:0] cur_chan_reg;
  logic in_seq_two_reg;
  logic range_reg;
  logic coding_reg;
  logic [1:0] power_reg;
  logic frame_done_reg;

  ctrl_fields_t ctrl;
  logic write_flag;
  logic [7:0] seq_one;
  logic [7:0] seq_two;
  logic [3:0] nxt_one;
  logic [3:0] nxt_two;
  logic [3:0] low_one;
  logic [3:0] low_two;
  logic [2:0] mask_next_chan;
  logic mask_next_two;
  logic [2:0] sweep_next_chan;
  logic [7:0] new_one;
  logic [7:0] new_two;
  logic [3:0] lo_new_one;
  logic [3:0] lo_new_two;
  logic ctrl_write;

  assign ctrl = decode_ctrl(word_sync_reg);
  assign write_flag = word_sync_reg[WRITE_FLAG_POS];
  assign seq_one = to_chan_order(mask_reg[15:8]); // [R10]
  assign seq_two = to_chan_order(mask_reg[7:0]); // [R10]
  assign new_one = to_chan_order(word_sync_reg[15:8]); // [R10]
  assign new_two = to_chan_order(word_sync_reg[7:0]); // [R10]

  // ****************************************
  // Next-channel search through the mask
  // ****************************************
  always_comb begin
    // Successor of the channel about to convert, not of the one just done
    nxt_one = first_at_or_above(seq_one, 4'({1'b0, next_chan_reg}) + 4'h1);
    nxt_two = first_at_or_above(seq_two, 4'({1'b0, next_chan_reg}) + 4'h1);
    low_one = first_at_or_above(seq_one, 4'h0);
    low_two = first_at_or_above(seq_two, 4'h0);
    lo_new_one = first_at_or_above(new_one, 4'h0);
    lo_new_two = first_at_or_above(new_two, 4'h0);
    mask_next_two = 1'b0;
    mask_next_chan = next_chan_reg;
    if (!in_seq_two_reg && nxt_one != 4'h8) begin
      mask_next_chan = nxt_one[2:0]; // [R12]
    end else if (!in_seq_two_reg && low_two != 4'h8) begin
      mask_next_chan = low_two[2:0]; // [R11]
      mask_next_two = 1'b1;
    end else if (in_seq_two_reg && nxt_two != 4'h8) begin
      mask_next_chan = nxt_two[2:0]; // [R12]
      mask_next_two = 1'b1;
    end else if (low_one != 4'h8) begin
      mask_next_chan = low_one[2:0]; // [R11]
    end else if (low_two != 4'h8) begin
      mask_next_chan = low_two[2:0];
      mask_next_two = 1'b1;
    end
  end

  always_comb begin
    if (next_chan_reg >= sweep_last_reg) begin
      sweep_next_chan = CHAN_RESET; // [R6]
    end else begin
      sweep_next_chan = next_chan_reg + 3'h1; // [R6]
    end
  end

  // ****************************************
  // Mode and mask update per completed frame
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mode_reg <= MODE_SINGLE; // [R19]
    end else if (frame_evt) begin
      unique case (mode_reg)
        MODE_MASK_LOAD: begin
          mode_reg <= MODE_MASK_RUN; // [R3]
        end
        default: begin
          if (write_flag) begin
            unique case ({ctrl.seq_enable, ctrl.mask_prog})
              2'b00: mode_reg <= MODE_SINGLE; // [R1] [R13]
              2'b01: mode_reg <= MODE_MASK_LOAD; // [R2]
              2'b10: mode_reg <= mode_reg; // [R5]
              2'b11: mode_reg <= MODE_SWEEP; // [R6]
            endcase
          end
        end
      endcase
    end
  end

  // Mask only ever loads from the frame that follows a 0,1 write
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mask_reg <= MASK_RESET; // [R19]
    end else if (frame_evt && mode_reg == MODE_MASK_LOAD) begin
      mask_reg <= word_sync_reg; // [R2] [R9] [R4] [R7]
    end
  end

  // Range, coding and power bits apply on any write except the mask word [R5]
  assign ctrl_write = frame_evt && write_flag && mode_reg != MODE_MASK_LOAD;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      range_reg <= 1'b0;
    end else if (ctrl_write) begin
      range_reg <= ctrl.range_single_ref; // [R15]
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      coding_reg <= 1'b0;
    end else if (ctrl_write) begin
      coding_reg <= ctrl.coding_binary;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      power_reg <= POWER_RESET;
    end else if (ctrl_write) begin
      power_reg <= ctrl.power_mode;
    end
  end

  // Final sweep channel moves only on a write that starts a sweep
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sweep_last_reg <= CHAN_RESET;
    end else if (ctrl_write && ctrl.seq_enable && ctrl.mask_prog) begin
      sweep_last_reg <= ctrl.chan_addr; // [R6]
    end
  end

  // ****************************************
  // Channel selection for the next frame
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cur_chan_reg <= CHAN_RESET;
    end else if (frame_evt) begin
      cur_chan_reg <= next_chan_reg; // [R16]
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      next_chan_reg <= CHAN_RESET;
      in_seq_two_reg <= 1'b0;
    end else if (frame_evt) begin
      if (mode_reg == MODE_MASK_LOAD) begin
        // The mask lands on this same edge, so search the incoming word
        next_chan_reg <= (lo_new_one != 4'h8) ? lo_new_one[2:0] : lo_new_two[2:0]; // [R3] [R12]
        in_seq_two_reg <= (lo_new_one == 4'h8);
      end else if (write_flag && !ctrl.seq_enable) begin
        next_chan_reg <= ctrl.chan_addr; // [R1] [R16]
        in_seq_two_reg <= 1'b0;
      end else if (write_flag && ctrl.mask_prog) begin
        next_chan_reg <= CHAN_RESET; // [R6]
        in_seq_two_reg <= 1'b0;
      end else if (mode_reg == MODE_MASK_RUN) begin
        next_chan_reg <= mask_next_chan; // [R3] [R4]
        in_seq_two_reg <= mask_next_two;
      end else if (mode_reg == MODE_SWEEP) begin
        next_chan_reg <= sweep_next_chan; // [R6]
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      frame_done_reg <= 1'b0;
    end else begin
      frame_done_reg <= frame_evt;
    end
  end

  // Mask never reaches an output: write-only by construction [R7]
  assign conv_chan_o = cur_chan_reg;
  assign range_single_ref_o = range_reg;
  assign coding_binary_o = coding_reg;
  assign power_mode_o = power_reg;
  assign seq_mode_o = mode_reg;
  assign frame_done_o = frame_done_reg;

endmodule // adc_channel_sequencer

// ---- design/adc_seq_pkg.sv ----
// Purpose: shared constants and types for the converter channel sequencer
// Assumes: 16-bit serial frames, MSB first, sampled on serial clock falling edges
// Notes: control word layout covers the write, sequencer, address, power, range and coding fields only
package adc_seq_pkg;

  // ****************************************
  // Frame and control word layout
  // ****************************************
  localparam int FRAME_BITS = 16;
  localparam int WRITE_FLAG_POS = 15;
  localparam int SEQ_ENABLE_POS = 10;
  localparam int CHAN_ADDR_HI = 8;
  localparam int CHAN_ADDR_LO = 6;
  localparam int POWER_MODE_HI = 5;
  localparam int POWER_MODE_LO = 4;
  localparam int MASK_PROG_POS = 3;
  localparam int RANGE_POS = 1;
  localparam int CODING_POS = 0;
  localparam int MUX_SWITCH_EDGE = 14;
  localparam int CHANNELS = 8;

  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [2:0] CHAN_RESET = 3'h0;
  localparam logic [1:0] POWER_RESET = 2'h3;
  localparam int SCLK_TARGET_MHZ = 20;
  localparam int THROUGHPUT_KSPS = 1000;
  localparam int SCLK_PER_SAMPLE = SCLK_TARGET_MHZ * 1000 / THROUGHPUT_KSPS;

  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_MASK_LOAD,
    MODE_MASK_RUN,
    MODE_SWEEP
  } seq_mode_t;

  // Control fields decoded from one write
  typedef struct packed {
    logic seq_enable;
    logic mask_prog;
    logic [2:0] chan_addr;
    logic [1:0] power_mode;
    logic range_single_ref;
    logic coding_binary;
  } ctrl_fields_t;

  // A completed frame handed from the link domain
  typedef struct packed {
    logic [15:0] word;
    logic [2:0] next_chan;
  } frame_t;

endpackage

// ---- design/frame_shifter.sv ----
// Purpose: serial link side: shifts frame bits, counts edges, drives the mux select
// Assumes: runs on the serial clock, frames bounded by active-low chip select
// Notes: the frame's last edge and chip select release end the frame
`timescale 1ns/1ns
module frame_shifter
  import adc_seq_pkg::*;
(
  // Link pins
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  // Next channel from the core (stable outside the switch edge)
  input wire logic [2:0] next_chan_i,
  // Frame out
  output logic [15:0] shift_o,
  output logic frame_toggle_o,
  output logic [2:0] mux_chan_o
);

  // No reset reaches the link side, so power-up values stand in for one
  logic [4:0] edge_cnt_reg = 5'h00;
  logic [15:0] shift_reg = 16'h0000;
  logic [15:0] word_reg = 16'h0000;
  logic frame_toggle_reg = 1'b0;
  logic [2:0] mux_chan_reg = CHAN_RESET;

  // ****************************************
  // Falling-edge shift and count
  // ****************************************
  // Chip select high acts as the frame's own reset since the clock may stop
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      edge_cnt_reg <= 5'h00;
    end else if (edge_cnt_reg != 5'(FRAME_BITS)) begin
      edge_cnt_reg <= edge_cnt_reg + 5'h01;
    end
  end

  always_ff @(negedge sclk_i) begin
    if (!cs_n_i && edge_cnt_reg < 5'(FRAME_BITS)) begin
      shift_reg <= {shift_reg[14:0], din_i}; // [R8]
    end
  end

  // Toggle once at the sixteenth falling edge; toggling crosses cleanly
  // Word kept apart from the shifter, which the next frame reuses early
  always_ff @(negedge sclk_i) begin
    if (!cs_n_i && edge_cnt_reg == 5'(FRAME_BITS - 1)) begin
      frame_toggle_reg <= ~frame_toggle_reg; // [R8]
      word_reg <= {shift_reg[14:0], din_i}; // [R8]
    end
  end

  always_ff @(negedge sclk_i) begin
    if (!cs_n_i && edge_cnt_reg == 5'(MUX_SWITCH_EDGE - 1)) begin
      mux_chan_reg <= next_chan_i; // [R17]
    end
  end

  assign shift_o = word_reg;
  assign frame_toggle_o = frame_toggle_reg;
  assign mux_chan_o = mux_chan_reg;

endmodule // frame_shifter

// ---- verification/adc_channel_sequencer_props.sv ----
// Purpose: port checks of the channel sequencer
// Assumes: results other than mux_chan_o move only with frame_done_o
// Notes: falling edges are counted here to place the mux switch
`timescale 1ns/1ns
module seq_props_chk
  import adc_seq_pkg::*;
#(
  parameter int NUM_CHANNELS = CHANNELS
) (
  // Clock, reset, link
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  // Results
  input wire logic [2:0] mux_chan_o,
  input wire logic [2:0] conv_chan_o,
  input wire logic range_single_ref_o,
  input wire logic coding_binary_o,
  input wire logic [1:0] power_mode_o,
  input wire seq_mode_t seq_mode_o,
  input wire logic frame_done_o
);
  logic [4:0] edge_cnt = 5'h00;
  // Cleared by chip select, so a short frame cannot skew the count
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      edge_cnt <= 5'h00;
    end else if (edge_cnt != 5'h1f) begin
      edge_cnt <= edge_cnt + 5'h01;
    end
  end
  property p_conv;
    @(posedge core_clk_i) disable iff (rst_i) $changed(conv_chan_o) |-> frame_done_o;
  endproperty
  a_conv: assert property (p_conv) else $error("channel moved off frame");
  property p_mode;
    @(posedge core_clk_i) disable iff (rst_i) $changed(seq_mode_o) |-> frame_done_o;
  endproperty
  a_mode: assert property (p_mode) else $error("mode moved off frame");
  property p_ctl;
    @(posedge core_clk_i) disable iff (rst_i)
      $changed({range_single_ref_o, coding_binary_o, power_mode_o}) |-> frame_done_o;
  endproperty
  a_ctl: assert property (p_ctl) else $error("control moved off frame");
  property p_load;
    @(posedge core_clk_i) disable iff (rst_i)
      frame_done_o && $past(seq_mode_o) == MODE_MASK_LOAD |-> seq_mode_o == MODE_MASK_RUN
      && $stable(power_mode_o) && $stable(range_single_ref_o);
  endproperty
  a_load: assert property (p_load) else $error("mask frame misread");
  property p_sweep;
    @(posedge core_clk_i) disable iff (rst_i)
      frame_done_o && $past(seq_mode_o) == MODE_SWEEP && seq_mode_o == MODE_SWEEP
      |-> conv_chan_o == 3'h0 || conv_chan_o == $past(conv_chan_o) + 3'h1;
  endproperty
  a_sweep: assert property (p_sweep) else $error("sweep skipped a channel");
  property p_mux;
    @(posedge core_clk_i) disable iff (rst_i) frame_done_o |-> mux_chan_o == conv_chan_o;
  endproperty
  a_mux: assert property (p_mux) else $error("mux differs from channel");
  property p_edge;
    @(negedge sclk_i) disable iff (rst_i) edge_cnt != 5'h0d |=> $stable(mux_chan_o);
  endproperty
  a_edge: assert property (p_edge) else $error("mux moved off edge 14");
  property p_reset;
    @(posedge core_clk_i) rst_i |=> seq_mode_o == MODE_SINGLE
      && power_mode_o == POWER_RESET && !frame_done_o && !range_single_ref_o;
  endproperty
  a_reset: assert property (p_reset) else $error("bad reset state");
  c_run: cover property (@(posedge core_clk_i) frame_done_o && seq_mode_o == MODE_MASK_RUN);
  c_sweep: cover property (@(posedge core_clk_i) frame_done_o && seq_mode_o == MODE_SWEEP);
  c_single: cover property (@(posedge core_clk_i) frame_done_o && seq_mode_o == MODE_SINGLE);
endmodule // seq_props_chk

bind adc_channel_sequencer seq_props_chk #(.NUM_CHANNELS(NUM_CHANNELS)) props_u (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
  .din_i(din_i), .mux_chan_o(mux_chan_o), .conv_chan_o(conv_chan_o),
  .range_single_ref_o(range_single_ref_o), .coding_binary_o(coding_binary_o),
  .power_mode_o(power_mode_o), .seq_mode_o(seq_mode_o), .frame_done_o(frame_done_o));

// ---- verification/host_serial_model.sv ----
// Purpose: host side of the serial link
// Assumes: serial clock idles high and runs only inside frames
// Notes: data line is inverted once released so stale bits are not trusted
`timescale 1ns/1ns
module host_serial_model (
  // Link pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o
);
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    din_o = 1'b0;
  end
  // Fewer edges than a word are sent on purpose, to be refused
  task automatic send(input logic [15:0] word, input int edges);
    cs_n_o = 1'b0;
    #43;
    for (int i = 0; i < edges; i++) begin
      din_o = word[15 - i];
      #80 sclk_o = 1'b0;
      #80 sclk_o = 1'b1;
    end
    #80;
    cs_n_o = 1'b1;
    din_o = ~din_o;
  endtask
endmodule // host_serial_model

// ---- verification/adc_channel_sequencer_tb.sv ----
// Purpose: self-checking bench for the channel sequencer
// Assumes: one host frame at a time
// Notes: results are snapshotted at each frame_done_o pulse
`timescale 1ns/1ns
module adc_channel_sequencer_tb;
  import adc_seq_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic sclk, cs_n, din, rng, cod, done;
  logic [2:0] mux_chan, conv_chan, s_conv, s_mux, e_conv, e_next, e_last;
  logic [1:0] pm;
  logic [3:0] s_ctl, e_ctl, e_pos;
  logic [15:0] lfsr = 16'h0048;
  logic [15:0] e_mask;
  seq_mode_t mode, s_mode, e_mode;
  int error_cnt = 0;
  int tests_run = 0;
  int n_done = 0;
  int cyc = 0;

  always #5 core_clk = ~core_clk;

  host_serial_model host_u (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din));
  adc_channel_sequencer #(.NUM_CHANNELS(CHANNELS)) dut_u (
    .core_clk_i(core_clk), .rst_i(rst), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
    .mux_chan_o(mux_chan), .conv_chan_o(conv_chan), .range_single_ref_o(rng),
    .coding_binary_o(cod), .power_mode_o(pm), .seq_mode_o(mode), .frame_done_o(done));

  // ****
  // Monitor and timeout
  // ****
  always @(posedge core_clk) begin
    #1;
    cyc++;
    if (done === 1'b1) begin
      n_done++;
      s_conv = conv_chan;
      s_mux = mux_chan;
      s_mode = mode;
      s_ctl = {rng, cod, pm};
    end
    if (cyc == 40000) begin
      error_cnt++;
      conclude();
    end
  end

  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Power field never 00, which the device does not accept
  function automatic logic [15:0] ctl(input logic sq, input logic mp, input logic [2:0] a);
    lfsr = step(lfsr);
    return {1'b1, 4'h0, sq, 1'b0, a, ((lfsr[1:0] == 2'h0) ? 2'h3 : lfsr[1:0]), mp, 1'b0,
      lfsr[3:2]};
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_ch(input logic [2:0] got, input logic [2:0] exp);
    chk({13'h0, got}, {13'h0, exp});
  endtask

  task automatic advance();
    if (e_mode == MODE_SWEEP) e_next = (e_next == e_last) ? 3'h0 : e_next + 3'h1;
    if (e_mode == MODE_MASK_RUN) begin
      e_pos = e_pos + 4'h1;
      while (e_mask[4'hf - e_pos] !== 1'b1) e_pos = e_pos + 4'h1;
      e_next = e_pos[2:0];
    end
  endtask

  task automatic predict(input logic [15:0] w);
    e_conv = e_next;
    if (e_mode == MODE_MASK_LOAD) begin
      e_mask = w;
      e_mode = MODE_MASK_RUN;
      e_pos = 4'hf;
      advance();
    end else if (w[15] && {w[10], w[3]} != 2'b10) begin
      e_ctl = {w[1], w[0], w[5:4]};
      e_mode = w[10] ? MODE_SWEEP : (w[3] ? MODE_MASK_LOAD : MODE_SINGLE);
      e_last = w[8:6];
      e_next = w[10] ? 3'h0 : w[8:6];
    end else begin
      if (w[15]) e_ctl = {w[1], w[0], w[5:4]};
      advance();
    end
  endtask

  task automatic frame(input logic [15:0] w, input int edges);
    int d0;
    logic look;
    d0 = n_done;
    look = (e_mode != MODE_MASK_LOAD);
    host_u.send(w, edges);
    for (int k = 0; k < 12 && n_done == d0; k++) @(posedge core_clk);
    #2;
    chk(16'(n_done - d0), 16'(edges / 16));
    if (edges == 16) begin
      predict(w);
      if (look) begin
        chk_ch(s_conv, e_conv);
        chk_ch(s_mux, e_conv);
      end
      chk(16'(s_mode), 16'(e_mode));
      chk(16'(s_ctl), 16'(e_ctl));
    end
  endtask

  task automatic idle(input int n);
    for (int i = 0; i < n; i++) begin
      lfsr = step(lfsr);
      frame({1'b0, lfsr[14:0]}, 16);
    end
  endtask

  task automatic load(input logic [15:0] m, input int n);
    frame(ctl(1'b0, 1'b1, lfsr[2:0]), 16);
    frame(m, 16);
    idle(n);
  endtask

  task automatic conclude();
    $display("mismatches=%0d checks=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    e_mode = MODE_SINGLE;
    e_next = CHAN_RESET;
    e_ctl = {2'h0, POWER_RESET};
    e_mask = MASK_RESET;
    e_pos = 4'h0;
    e_last = 3'h0;
    repeat (12) @(posedge core_clk);
    #1;
    chk(16'(mode), 16'(MODE_SINGLE));
    chk({12'h0, rng, cod, pm}, {12'h0, e_ctl});
    rst = 1'b0;
    for (int i = 0; i < 8; i++) frame(ctl(1'b0, 1'b0, 3'(i)), 16);
    idle(2);
    frame(ctl(1'b0, 1'b1, 3'h5), 10);
    load(16'ha581, 10);
    frame(ctl(1'b1, 1'b0, 3'h2), 16);
    idle(6);
    load(16'h5a00, 6);
    for (int i = 0; i < 3; i++) load(step(lfsr), 9);
    frame(ctl(1'b0, 1'b0, 3'h3), 16);
    idle(1);
    frame(ctl(1'b1, 1'b1, 3'h7), 16);
    idle(9);
    frame(ctl(1'b1, 1'b1, 3'h0), 16);
    idle(2);
    frame(ctl(1'b1, 1'b1, lfsr[2:0]), 16);
    idle(6);
    frame(ctl(1'b0, 1'b0, 3'h1), 16);
    idle(1);
    conclude();
  end
endmodule // adc_channel_sequencer_tb
